// ---- rtl/reset_ctl_defs.vh ----
`ifndef RESET_CTL_DEFS_VH
`define RESET_CTL_DEFS_VH
// wishbone register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_TMODE 8'h08
// control register fields (write one to act, self clearing)
`define CTRL_STOP_BIT 0
`define CTRL_HALT_BIT 1
// status register fields
`define ST_STOP_BIT 0
`define ST_HALT_BIT 1
`define ST_CORE_BIT 2
`define ST_CTRL_BIT 3
`define ST_OSC_BIT 4
`define ST_THR_BIT 5
`define ST_CE_BIT 6
`define ST_LOW_BIT 7
`define ST_CORE_PEND_BIT 8
// timer mode selection: 0000 selects the 100 ms carry period
`define TMODE_W 4
`define TMODE_RESET 4'h0
`define TMODE_LONG 4'h0
// carry periods in microseconds and the clock rate in kHz
`define CARRY_LONG_US 100000
`define CARRY_SHORT_US 5000
`define CLK_KHZ 25000
`endif

// ---- rtl/carry_pulse_gen.v ----
`timescale 1ns/1ps
`include "reset_ctl_defs.vh"
// timer carry set pulse generator; the set pulse rises at mid period
module carry_pulse_gen #(
    parameter LONG_CYC = (`CARRY_LONG_US / 1000) * `CLK_KHZ,
    parameter SHORT_CYC = (`CARRY_SHORT_US / 1000) * `CLK_KHZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire restart_i,
    input wire long_i,
    output reg set_edge_o
);
    reg [31:0] count;
    wire [31:0] period;
    assign period = long_i ? LONG_CYC : SHORT_CYC;
    // restart aligns the first edge half a period later (50 ms at 100 ms)
    always @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            count <= 32'h0000_0000;
            set_edge_o <= 1'b0;
        end else begin
            set_edge_o <= (count == (period >> 1) - 32'h0000_0001);
            if (count >= period - 32'h0000_0001) begin
                count <= 32'h0000_0000;
            end else begin
                count <= count + 32'h0000_0001;
            end
        end
    end
endmodule // carry_pulse_gen

// ---- rtl/reset_ctl.v ----
// Functional notes
// - without clock-stop, chip-enable rise gives core reset at next carry set edge
// - chip-enable reset without clock-stop keeps timer mode selection
// - clock-stop entry asserts halt, control-register and core reset strobes together
// - clock-stop entry clears timer mode to 0000, the 100 ms period
// - halt strobe stays asserted while chip-enable stays low in clock-stop
// - clock-stop stops oscillator; chip-enable rise ends it and restarts oscillation
// - after leaving clock-stop, halt ends at next carry set edge, start at zero
// - supply-low flag stops oscillator, halts, holds all three strobes
// - supply-low clear restarts oscillation and drops control-register and core reset strobes together; halt stays until next carry edge
// - after power-on, 100 ms period, start at zero at next carry edge
// - power-on initializes counter, stack, system and control registers while flag active
// - supply threshold select is 3.5 V normally, 2.2 V in clock-stop
// - in normal operation supply-low stops device regardless of chip-enable
// - supply-low in clock-stop shows only as threshold select dropping; recovery waits 50 ms, starts at zero
// - chip-enable rising with supply or during power-on halt runs power-on only
// - chip-enable rise after power-on completes restarts at next carry edge
// - chip-enable reset asserts core reset only, not the other two strobes
// - halt strobe holds halt until the timer carry flip-flop is set
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "reset_ctl_defs.vh"
module reset_ctl #(
    parameter LONG_CYC = (`CARRY_LONG_US / 1000) * `CLK_KHZ,
    parameter SHORT_CYC = (`CARRY_SHORT_US / 1000) * `CLK_KHZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire chip_enable_i,
    input wire supply_low_flag_i,
    input wire stop_exec_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg forced_halt_strobe_o,
    output reg control_reg_reset_strobe_o,
    output reg core_reset_o,
    output reg osc_enable_o,
    output reg low_threshold_sel_o,
    output reg [3:0] timer_mode_o
);
    ////////////////////////////////////////////////////////////////////////
    // state encoding, one hot
    localparam RUN = 4'b0001;
    localparam STOP = 4'b0010;
    localparam WAIT = 4'b0100;
    localparam PWR = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;
    reg ce_meta, ce_sync, ce_prev, ce_rise;
    reg low_meta, low_sync;
    reg core_pend;
    reg [3:0] tmode;
    reg restart;
    reg stop_req;
    wire carry_edge;
    wire wb_req;

    ////////////////////////////////////////////////////////////////////////
    // synchronizers; first stage read only by the second
    always @(posedge clk_i) begin
        if (rst_i) begin
            ce_meta <= 1'b0;
            ce_sync <= 1'b0;
            ce_prev <= 1'b0;
            ce_rise <= 1'b0;
            low_meta <= 1'b1;
            low_sync <= 1'b1;
        end else begin
            ce_meta <= chip_enable_i;
            ce_sync <= ce_meta;
            ce_prev <= ce_sync;
            ce_rise <= ce_sync & ~ce_prev;
            low_meta <= supply_low_flag_i;
            low_sync <= low_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carry pulse source; restart realigns so first edge lands 50 ms later
    carry_pulse_gen #(
        .LONG_CYC(LONG_CYC),
        .SHORT_CYC(SHORT_CYC)
    ) u_carry (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .long_i(tmode == `TMODE_LONG),
        .set_edge_o(carry_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always @* begin
        next_state = state;
        case (state)
            RUN: begin
                if (low_sync) begin
                    next_state = PWR;
                end else if (stop_req) begin
                    next_state = STOP;
                end
            end
            STOP: begin
                // supply-low here only swaps to power-on; outside only the threshold select drops
                if (low_sync) begin
                    next_state = PWR;
                end else if (ce_rise) begin
                    next_state = WAIT;
                end
            end
            WAIT: begin
                if (low_sync) begin
                    next_state = PWR;
                end else if (carry_edge) begin
                    next_state = RUN;
                end
            end
            PWR: begin
                if (!low_sync) begin
                    next_state = WAIT;
                end
            end
            default: begin
                next_state = PWR;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state, pending core reset, restart and timer mode register
    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= PWR;
            tmode <= `TMODE_RESET;
            core_pend <= 1'b0;
            restart <= 1'b0;
        end else begin
            state <= next_state;
            restart <= (next_state == WAIT) && (state != WAIT);
            if (next_state == PWR || (state == RUN && next_state == STOP)) begin
                tmode <= `TMODE_RESET;
            end else if (wb_req && wb_we_i && wb_adr_i == `ADDR_TMODE && wb_sel_i[0]) begin
                tmode <= wb_dat_i[3:0];
            end
            // chip-enable in running mode arms core reset for next carry edge
            if (state != RUN || next_state != RUN) begin
                core_pend <= 1'b0;
            end else if (ce_rise) begin
                core_pend <= 1'b1;
            end else if (carry_edge) begin
                core_pend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs; core reset alone in chip-enable reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            forced_halt_strobe_o <= 1'b1;
            control_reg_reset_strobe_o <= 1'b1;
            core_reset_o <= 1'b1;
            osc_enable_o <= 1'b0;
            low_threshold_sel_o <= 1'b0;
            timer_mode_o <= `TMODE_RESET;
        end else begin
            forced_halt_strobe_o <= (next_state != RUN);
            control_reg_reset_strobe_o <= (next_state == STOP) || (next_state == PWR);
            core_reset_o <= (next_state == STOP) || (next_state == PWR)
                || (core_pend && carry_edge);
            osc_enable_o <= (next_state == RUN) || (next_state == WAIT);
            low_threshold_sel_o <= (next_state == STOP);
            timer_mode_o <= tmode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack dropped the cycle after
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            stop_req <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            // clock-stop request from software or the instruction decoder
            stop_req <= stop_exec_i || (wb_req && wb_we_i && wb_adr_i == `ADDR_CTRL
                && wb_sel_i[0] && wb_dat_i[`CTRL_STOP_BIT]);
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == `ADDR_STATUS) begin
                    wb_dat_o <= {23'h00_0000, core_pend, low_sync, ce_sync, low_threshold_sel_o,
                        osc_enable_o, control_reg_reset_strobe_o, core_reset_o,
                        forced_halt_strobe_o, state == STOP};
                end else if (wb_adr_i == `ADDR_TMODE) begin
                    wb_dat_o <= {28'h000_0000, tmode};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end
endmodule // reset_ctl

// ---- tb/reset_ctl_sva.sv ----
`timescale 1ns/1ps
module reset_ctl_sva #(
    parameter LONG_CYC = 200
) (
    input wire clk_i,
    input wire rst_i,
    input wire chip_enable_i,
    input wire supply_low_flag_i,
    input wire stop_exec_i,
    input wire forced_halt_strobe_o,
    input wire control_reg_reset_strobe_o,
    input wire core_reset_o,
    input wire osc_enable_o,
    input wire low_threshold_sel_o,
    input wire [3:0] timer_mode_o
);
    // the release window allows for the pin synchronizer around the half period
    localparam int W1 = LONG_CYC / 2 - 3;
    localparam int W2 = LONG_CYC / 2 + 3;
    localparam int W3 = LONG_CYC + 8;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // all three strobes together
    wire full = forced_halt_strobe_o && control_reg_reset_strobe_o && core_reset_o;
    property p_low; supply_low_flag_i [*5] |-> full && !osc_enable_o; endproperty
    a_low: assert property (p_low) else $error("supply low not held");
    property p_stop; stop_exec_i && !forced_halt_strobe_o |-> ##[1:2] full && !osc_enable_o && low_threshold_sel_o; endproperty
    a_stop: assert property (p_stop) else $error("stop entry wrong");
    property p_mode; $rose(control_reg_reset_strobe_o) |-> ##[0:1] timer_mode_o == 4'h0; endproperty
    a_mode: assert property (p_mode) else $error("mode not cleared");
    property p_pulse; core_reset_o && !forced_halt_strobe_o |-> !control_reg_reset_strobe_o && $stable(timer_mode_o) ##1 !core_reset_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ce reset pulse wrong");
    property p_hold; low_threshold_sel_o |-> forced_halt_strobe_o; endproperty
    a_hold: assert property (p_hold) else $error("halt lost in stop");
    property p_rel; $fell(control_reg_reset_strobe_o) |-> !core_reset_o && osc_enable_o && forced_halt_strobe_o; endproperty
    a_rel: assert property (p_rel) else $error("release not together");
    property p_wait; $fell(control_reg_reset_strobe_o) && timer_mode_o == 4'h0 |-> ##[W1:W2] $fell(forced_halt_strobe_o); endproperty
    a_wait: assert property (p_wait) else $error("halt release time wrong");
    property p_ce; $rose(chip_enable_i) && !forced_halt_strobe_o && !low_threshold_sel_o |-> ##[1:W3] core_reset_o; endproperty
    a_ce: assert property (p_ce) else $error("no core reset after ce");
endmodule // reset_ctl_sva
bind reset_ctl reset_ctl_sva #(.LONG_CYC(LONG_CYC)) u_reset_ctl_sva (.*);

// ---- tb/supply_ce_model.sv ----
`timescale 1ns/1ps
module supply_ce_model (
    input wire clk_i,
    input wire ce_req_i,
    input wire low_req_i,
    output reg chip_enable_o = 1'b0,
    output reg supply_low_flag_o = 1'b1
);
    // pins are asynchronous to the core, so a one edge lag costs nothing
    always @(posedge clk_i) begin
        chip_enable_o <= ce_req_i;
        supply_low_flag_o <= low_req_i;
    end
endmodule // supply_ce_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic clk_i = 0, rst_i = 1, stop_exec_i = 0, ce_req = 0, low_req = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1, mode;
    logic [31:0] wb_dat_i = 32'h0000_0000, exp_q[$];
    wire [31:0] wb_dat_o;
    wire [3:0] timer_mode_o;
    wire wb_ack_o, forced_halt_strobe_o, control_reg_reset_strobe_o, core_reset_o, osc_enable_o, low_threshold_sel_o;
    wire chip_enable_i, supply_low_flag_i;
    int err_count = 0, samples_checked = 0, seed = 98, n;
    reset_ctl #(.LONG_CYC(200), .SHORT_CYC(20)) u_reset_ctl (.*);
    supply_ce_model u_supply_ce_model (.clk_i(clk_i), .ce_req_i(ce_req), .low_req_i(low_req),
        .chip_enable_o(chip_enable_i), .supply_low_flag_o(supply_low_flag_i));
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one classic cycle; values are read at the edge, before that edge's updates land
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
        if (k == 50) chk(32'h0000_0000, 32'h0000_0001);
        if (k == 50) stop_test();
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // s 0 waits for halt release, s 1 for the core reset pulse
    task automatic wait_sig(input int s, output int c);
        for (c = 0; c < 1000 && (s ? core_reset_o : !forced_halt_strobe_o) !== 1'b1; c++) @(posedge clk_i);
        if (c == 1000) chk(32'h0000_0000, 32'h0000_0001);
        if (c == 1000) stop_test();
    endtask
    // read results are matched against the oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) chk(32'h0000_0000, 32'h0000_0001);
            else chk(wb_dat_o, exp_q.pop_front());
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk({forced_halt_strobe_o, control_reg_reset_strobe_o, core_reset_o, osc_enable_o}, 4'b1110);
        low_req <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({forced_halt_strobe_o, control_reg_reset_strobe_o, core_reset_o, osc_enable_o}, 4'b1001);
        rd(8'h08, 32'h0000_0000);
        wait_sig(0, n);
        chk(n > 80 && n < 100, 1'b1);
        $display("power-on test done");
        mode = 4'h1 + 4'({$random(seed)} % 15);
        bus(1'b1, 8'h08, {28'h000_0000, mode});
        rd(8'h08, {28'h000_0000, mode});
        rd(8'h0C, 32'h0000_0000);
        ce_req <= 1'b1;
        wait_sig(1, n);
        chk({n < 40, forced_halt_strobe_o, control_reg_reset_strobe_o, timer_mode_o}, {3'b100, mode});
        @(posedge clk_i);
        chk(core_reset_o, 1'b0);
        $display("chip-enable test done");
        ce_req <= 1'b0;
        repeat (5) @(posedge clk_i);
        stop_exec_i <= 1'b1;
        @(posedge clk_i);
        stop_exec_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({forced_halt_strobe_o, control_reg_reset_strobe_o, core_reset_o, osc_enable_o, low_threshold_sel_o,
            timer_mode_o}, {5'b11101, 4'h0});
        repeat (150) @(posedge clk_i);
        chk(forced_halt_strobe_o, 1'b1);
        ce_req <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({forced_halt_strobe_o, control_reg_reset_strobe_o, osc_enable_o}, 3'b101);
        wait_sig(0, n);
        chk(n > 94 && n < 106, 1'b1);
        $display("clock-stop test done");
        bus(1'b1, 8'h00, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        chk(low_threshold_sel_o, 1'b1);
        low_req <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({forced_halt_strobe_o, control_reg_reset_strobe_o, core_reset_o, osc_enable_o}, 4'b1110);
        low_req <= 1'b0;
        repeat (6) @(posedge clk_i);
        wait_sig(0, n);
        chk(n > 94 && n < 106, 1'b1);
        $display("supply-low in stop test done");
        stop_test();
    end
endmodule // testbench
